// *** prlk_pkg.sv ***
// package: constants, state and carrier types of the peripheral register lock and key
package prlk_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_GROUPS = 16;
    localparam int unsigned GROUP_W    = 4;
    localparam int unsigned KEY_W      = 8;

    // ------------------------------------------------------------
    // key sequence and reset values
    // ------------------------------------------------------------
    localparam logic [KEY_W-1:0]      KEY_FIRST_DEFAULT  = 8'hA5;
    localparam logic [KEY_W-1:0]      KEY_SECOND_DEFAULT = 8'hF1;
    localparam logic [NUM_GROUPS-1:0] LOCK_RESET         = 16'h0000;
    localparam logic [NUM_GROUPS-1:0] RUN_RESET          = 16'hFFFF;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PRLK_CLOSED    = 3'h1,
        PRLK_FIRST_OK  = 3'h2,
        PRLK_OPEN      = 3'h4
    } prlk_key_state_t;

    typedef struct packed {
        logic               wr;
        logic               rd;
        logic [GROUP_W-1:0] group;
    } prlk_access_t;

    typedef struct packed {
        prlk_key_state_t         key_state;
        logic [NUM_GROUPS-1:0]   lock_word;
        logic [NUM_GROUPS-1:0]   run_enable;
    } prlk_state_t;

    localparam prlk_state_t STATE_RESET = '{
        key_state:  PRLK_CLOSED,
        lock_word:  LOCK_RESET,
        run_enable: RUN_RESET
    };

endpackage

// *** prlk_lock_key.sv ***
// module: key sequence, lock word, write gating and debug freeze per peripheral group
// What this block does
// R01: each lock word bit protects its own peripheral group.
// R02: software writes the key sequence first; lock changes are refused until then.
// R03: any key write while open closes the lock words again.
// R04: key status read shows whether the lock words are open.
// R05: writes to a locked group are dropped; contents stay unchanged.
// R06: reads of every group pass whatever the lock state.
// R07: each group can be set to freeze or run while the core is halted.
// R08: a lock bit at one protects its group, such as the reset source unit.
// R09: two-word parameterised key; any mismatch while closed restarts detection.
`timescale 1ns/1ps
`default_nettype none

module prlk_lock_key #(
    parameter logic [prlk_pkg::KEY_W-1:0] KEY_FIRST  = prlk_pkg::KEY_FIRST_DEFAULT,
    parameter logic [prlk_pkg::KEY_W-1:0] KEY_SECOND = prlk_pkg::KEY_SECOND_DEFAULT
) (
    input  wire logic                              clock,
    input  wire logic                              rst,
    input  wire logic                              ce,
    input  wire logic                              key_wr,
    input  wire logic [prlk_pkg::KEY_W-1:0]        key_wdata,
    output logic                                   key_open,
    output logic [2:0]                             key_stage,
    input  wire logic                              lock_wr,
    input  wire logic [prlk_pkg::NUM_GROUPS-1:0]   lock_wdata,
    output logic [prlk_pkg::NUM_GROUPS-1:0]        peripheral_lock_words,
    input  wire prlk_pkg::prlk_access_t            periph_access,
    output logic                                   periph_wr_grant,
    output logic                                   periph_wr_dropped,
    output logic                                   periph_rd_grant,
    input  wire logic                              core_halted,
    input  wire logic [prlk_pkg::NUM_GROUPS-1:0]   freeze_sel,
    output logic [prlk_pkg::NUM_GROUPS-1:0]        run_enable
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // all state lives in one struct; next_s is its combinational copy
    prlk_pkg::prlk_state_t s;
    prlk_pkg::prlk_state_t next_s;
    // per group: the access targets this group and its lock bit is set
    logic [prlk_pkg::NUM_GROUPS-1:0] group_hit;

    always_comb
    begin
        next_s = s;
        if (key_wr)
        begin
            unique case (s.key_state)
                prlk_pkg::PRLK_CLOSED:
                begin
                    // R09
                    if (key_wdata == KEY_FIRST)
                        next_s.key_state = prlk_pkg::PRLK_FIRST_OK;
                end
                prlk_pkg::PRLK_FIRST_OK:
                begin
                    // a stray first word counts as a fresh start, not a failure
                    if (key_wdata == KEY_SECOND)
                        next_s.key_state = prlk_pkg::PRLK_OPEN; // R02
                    else if (key_wdata == KEY_FIRST)
                        next_s.key_state = prlk_pkg::PRLK_FIRST_OK;
                    else
                        next_s.key_state = prlk_pkg::PRLK_CLOSED; // R09
                end
                prlk_pkg::PRLK_OPEN:
                begin
                    next_s.key_state = prlk_pkg::PRLK_CLOSED; // R03
                end
                default:
                begin
                    next_s.key_state = prlk_pkg::PRLK_CLOSED;
                end
            endcase
        end

        // lock word is only taken while open; a key write in the same cycle still closes
        if (lock_wr && (s.key_state == prlk_pkg::PRLK_OPEN))
            next_s.lock_word = lock_wdata; // R02

        // registered so a halt edge cannot glitch a group's run gate
        next_s.run_enable = ~(freeze_sel & {prlk_pkg::NUM_GROUPS{core_halted}}); // R07
    end

    always_ff @(posedge clock)
    begin
        // reset wins over the clock enable so a frozen block still clears
        if (rst)
            s <= prlk_pkg::STATE_RESET;
        else if (ce)
            s <= next_s;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < prlk_pkg::NUM_GROUPS; g++)
        begin : gen_group
            // R01
            // group number cut to the width of the group field
            assign group_hit[g] = (periph_access.group == prlk_pkg::GROUP_W'(g))
                                  && s.lock_word[g];
        end
    endgenerate

    // status comes straight from the state register, never from next_s
    assign key_open              = (s.key_state == prlk_pkg::PRLK_OPEN); // R04
    assign key_stage             = s.key_state;
    assign peripheral_lock_words = s.lock_word;
    assign run_enable            = s.run_enable;
    // gating is combinational so a locked write never reaches the target register
    assign periph_wr_grant       = periph_access.wr && !(|group_hit); // R05 R08
    assign periph_wr_dropped     = periph_access.wr && (|group_hit); // R05
    assign periph_rd_grant       = periph_access.rd; // R06

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // reset and clock enable
    // ------------------------------------------------------------
    a_reset_state: assert property ($past(rst) |-> key_stage == prlk_pkg::PRLK_CLOSED // R04
        && peripheral_lock_words == prlk_pkg::LOCK_RESET && run_enable == prlk_pkg::RUN_RESET)
        else $error("state wrong after reset");

    a_ce_hold: assert property (!ce |=> $stable(key_stage) // R02
        && $stable(peripheral_lock_words) && $stable(run_enable))
        else $error("state moved with clock enable low");

    // ------------------------------------------------------------
    // key sequence
    // ------------------------------------------------------------
    a_key_close: assert property (ce && key_wr && key_open |=> !key_open) // R03
        else $error("key write did not close");

    a_key_open_seq: assert property (ce && key_wr && key_wdata == KEY_FIRST && !key_open // R09
        ##1 ce && key_wr && key_wdata == KEY_SECOND |=> key_open)
        else $error("valid key sequence did not open");

    a_key_mismatch: assert property (ce && key_wr && !key_open && key_wdata != KEY_SECOND // R09
        |=> !key_open)
        else $error("mismatching key opened the lock");

    // a repeated first word is a fresh start, not a failure
    a_first_repeat: assert property (ce && key_wr && key_stage == prlk_pkg::PRLK_FIRST_OK // R09
        && key_wdata == KEY_FIRST |=> key_stage == prlk_pkg::PRLK_FIRST_OK)
        else $error("repeated first word left the first stage");

    a_stage_onehot: assert property ($onehot(key_stage)) // R04
        else $error("key stage not one-hot");

    // ------------------------------------------------------------
    // lock word
    // ------------------------------------------------------------
    a_lock_refused: assert property (ce && lock_wr && !key_open |=> // R02
        peripheral_lock_words == $past(peripheral_lock_words))
        else $error("lock word changed while closed");

    a_lock_taken: assert property (ce && lock_wr && key_open |=> // R02
        peripheral_lock_words == $past(lock_wdata))
        else $error("lock word not taken while open");

    a_lock_keeps_open: assert property (ce && lock_wr && !key_wr && key_open |=> key_open) // R02
        else $error("lock write closed the key");

    // key and lock write together while open: word taken and key closes
    a_pair_close: assert property (ce && key_wr && lock_wr && key_open |=> // R03
        !key_open && peripheral_lock_words == $past(lock_wdata))
        else $error("paired key and lock write mishandled");

    // reset may clear the word without the key being open
    a_status_cause: assert property (!$stable(peripheral_lock_words) && !$past(rst) // R04
        |-> $past(key_open))
        else $error("lock word changed without open status");

    // ------------------------------------------------------------
    // access gating
    // ------------------------------------------------------------
    a_wr_dropped: assert property (periph_access.wr // R05
        && peripheral_lock_words[periph_access.group] |-> !periph_wr_grant && periph_wr_dropped)
        else $error("write to locked group passed");

    a_wr_passed: assert property (periph_access.wr // R01
        && !peripheral_lock_words[periph_access.group] |-> periph_wr_grant)
        else $error("write to unlocked group dropped");

    a_wr_quiet: assert property (!periph_access.wr // R05
        |-> !periph_wr_grant && !periph_wr_dropped)
        else $error("write outputs active without a write");

    a_rd_passed: assert property (periph_access.rd |-> periph_rd_grant) // R06
        else $error("read refused");

    a_rd_quiet: assert property (!periph_access.rd |-> !periph_rd_grant) // R06
        else $error("read grant without a read");

    // ------------------------------------------------------------
    // debug freeze
    // ------------------------------------------------------------
    a_freeze_sel: assert property (ce |=> // R07
        run_enable == ~($past(freeze_sel) & {prlk_pkg::NUM_GROUPS{$past(core_halted)}}))
        else $error("run enable wrong under halt");

    // ------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------
    c_opened: cover property (ce && key_wr && key_open);
    c_lock_set: cover property (ce && lock_wr && key_open ##1 peripheral_lock_words != 16'h0000);
    c_drop: cover property (periph_wr_dropped);
    c_freeze: cover property (core_halted && freeze_sel != 16'h0000 ##1 ce);
    c_first_repeat: cover property (ce && key_wr && key_stage == prlk_pkg::PRLK_FIRST_OK
        && key_wdata == KEY_FIRST);

endmodule

`default_nettype wire

// *** prlk_lock_key_test.sv ***
// testbench: self-checking scenarios for the peripheral register lock and key
`timescale 1ns/1ps
`default_nettype none

module test_prlk_lock_key;
    logic                  clock, rst, ce, key_wr, lock_wr, core_halted;
    logic [7:0]            key_wdata;
    logic [15:0]           lock_wdata, freeze_sel, peripheral_lock_words, run_enable;
    logic                  key_open, periph_wr_grant, periph_wr_dropped, periph_rd_grant;
    logic [2:0]            key_stage;
    prlk_pkg::prlk_access_t periph_access;
    int                    errors, n_tests, cycles;

    prlk_lock_key prlk_lock_key_inst (.clock(clock), .rst(rst), .ce(ce), .key_wr(key_wr),
        .key_wdata(key_wdata), .key_open(key_open), .key_stage(key_stage), .lock_wr(lock_wr),
        .lock_wdata(lock_wdata), .peripheral_lock_words(peripheral_lock_words),
        .periph_access(periph_access), .periph_wr_grant(periph_wr_grant),
        .periph_wr_dropped(periph_wr_dropped), .periph_rd_grant(periph_rd_grant),
        .core_halted(core_halted), .freeze_sel(freeze_sel), .run_enable(run_enable));

    // ------------------------------------------------------------
    // clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // whole run needs about 50 cycles; the ceiling leaves a wide margin
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask

    // one-cycle strobes; the answer is read just after the taking edge
    task automatic put_key(input logic [7:0] d);
        @(posedge clock);
        #1;
        key_wr = 1'b1;
        key_wdata = d;
        @(posedge clock);
        #1;
        key_wr = 1'b0;
    endtask

    task automatic put_lock(input logic [15:0] d);
        @(posedge clock);
        #1;
        lock_wr = 1'b1;
        lock_wdata = d;
        @(posedge clock);
        #1;
        lock_wr = 1'b0;
    endtask

    task automatic access(input logic w, input logic [3:0] g, input logic grant, input logic drop);
        @(posedge clock);
        #1;
        periph_access = '{wr: w, rd: ~w, group: g};
        #1;
        chk("wr_grant", {15'h0, grant}, {15'h0, periph_wr_grant});
        chk("wr_dropped", {15'h0, drop}, {15'h0, periph_wr_dropped});
        chk("rd_grant", {15'h0, ~w}, {15'h0, periph_rd_grant});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_closed();
        chk("stage", 16'h0001, {13'h0, key_stage});
        chk("run", prlk_pkg::RUN_RESET, run_enable);
        put_lock(16'h00FF);
        chk("lock", 16'h0000, peripheral_lock_words);
        put_key(prlk_pkg::KEY_FIRST_DEFAULT);
        chk("stage", 16'h0002, {13'h0, key_stage});
        put_key(8'h00);
        chk("stage", 16'h0001, {13'h0, key_stage});
        put_key(prlk_pkg::KEY_SECOND_DEFAULT);
        chk("open", 16'h0000, {15'h0, key_open});
        put_key(prlk_pkg::KEY_FIRST_DEFAULT);
        put_key(prlk_pkg::KEY_FIRST_DEFAULT);
        chk("stage", 16'h0002, {13'h0, key_stage});
        put_key(prlk_pkg::KEY_SECOND_DEFAULT);
        chk("stage", 16'h0004, {13'h0, key_stage});
    endtask

    task automatic t_locked();
        put_lock(16'h0001);
        chk("lock", 16'h0001, peripheral_lock_words);
        chk("open", 16'h0001, {15'h0, key_open});
        access(1'b1, 4'h0, 1'b0, 1'b1);
        access(1'b1, 4'h1, 1'b1, 1'b0);
        access(1'b0, 4'h0, 1'b0, 1'b0);
        put_key(prlk_pkg::KEY_FIRST_DEFAULT);
        chk("stage", 16'h0001, {13'h0, key_stage});
        put_lock(16'h0000);
        chk("lock", 16'h0001, peripheral_lock_words);
        // a one-edge reset in mid-run clears the lock word again
        rst = 1'b1;
        @(posedge clock);
        #1;
        rst = 1'b0;
        chk("lock", prlk_pkg::LOCK_RESET, peripheral_lock_words);
        chk("stage", 16'h0001, {13'h0, key_stage});
        access(1'b1, 4'h0, 1'b1, 1'b0);
    endtask

    task automatic t_ce_debug();
        ce = 1'b0;
        freeze_sel = 16'h8003;
        core_halted = 1'b1;
        put_key(prlk_pkg::KEY_FIRST_DEFAULT);
        put_key(prlk_pkg::KEY_SECOND_DEFAULT);
        chk("stage", 16'h0001, {13'h0, key_stage});
        chk("run", prlk_pkg::RUN_RESET, run_enable);
        ce = 1'b1;
        @(posedge clock);
        #1;
        chk("run", 16'h7FFC, run_enable);
        core_halted = 1'b0;
        @(posedge clock);
        #1;
        chk("run", prlk_pkg::RUN_RESET, run_enable);
    endtask

    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        key_wr = 1'b0;
        lock_wr = 1'b0;
        core_halted = 1'b0;
        key_wdata = 8'h00;
        lock_wdata = 16'h0000;
        freeze_sel = 16'h0000;
        periph_access = '0;
        errors = 0;
        n_tests = 0;
        cycles = 0;
        repeat (20) @(posedge clock);
        #1; rst = 1'b0;
        t_closed();
        t_locked();
        t_ce_debug();
        stop_test();
    end
endmodule

`default_nettype wire
